// [obi_regs.vh]
// offsets, fields, reset values, command codes and timing of the option interpreter
`ifndef OBI_REGS_VH
`define OBI_REGS_VH

// ========
// register offsets (byte addresses)
`define OBI_REG_CONFIG      8'h00
`define OBI_REG_POWER       8'h04
`define OBI_REG_TIMEOUT     8'h08
`define OBI_REG_STATUS      8'h0c

// ========
// register fields and reset values
`define OBI_CFG_LF          0
`define OBI_CFG_HDR         1
`define OBI_CFG_GRP         2
`define OBI_CFG_AUTOFMT     3
`define OBI_CFG_REV         4
`define OBI_CFG_TM5         5
`define OBI_CFG_FM_LO       6
`define OBI_CFG_FM_HI       7
`define OBI_CFG_RST         8'h1c
`define OBI_POWER_RST       8'h04
`define OBI_POWER_KEYOFF    2
`define OBI_TIMEOUT_RST     8'h32

// ========
// command codes from the line decoder
`define OBI_C_FLOW_MODE     5'h01
`define OBI_C_HDR_OFF       5'h02
`define OBI_C_HDR_ON        5'h03
`define OBI_C_IDENT         5'h04
`define OBI_C_ACTIVE        5'h05
`define OBI_C_ALT_ACTIVE    5'h06
`define OBI_C_KEY_READ      5'h07
`define OBI_C_IN1_READ      5'h08
`define OBI_C_IN2_READ      5'h09
`define OBI_C_REV_PGN       5'h0a
`define OBI_C_RAW_ORDER     5'h0b
`define OBI_C_GRP_OFF       5'h0c
`define OBI_C_GRP_ON        5'h0d
`define OBI_C_AUTOFMT_OFF   5'h0e
`define OBI_C_AUTOFMT_ON    5'h0f
`define OBI_C_TM1           5'h10
`define OBI_C_TM5           5'h11
`define OBI_C_ALT_TM1       5'h12
`define OBI_C_ALT_TM5       5'h13
`define OBI_C_LF_OFF        5'h14
`define OBI_C_LF_ON         5'h15

// ========
// characters
`define OBI_CH_CR           8'h0d
`define OBI_CH_LF           8'h0a
`define OBI_CH_PROMPT       8'h3e

// ========
// timing
`define OBI_CLK_MHZ         125
`define OBI_LF_WAIT_US      500

`endif

// [obi_option_cmd.v]
// option command interpreter: flags, replies, linefeed wait, key stop, j1939 order
// ========
// Function
// - flow reply mode takes one digit: 0 automatic, 1 user reply, 2 user data.
// - modes 1 or 2 refused with error unless needed data and id are defined.
// - header display on shows whole message; off omits header bytes.
// - crc field is never shown, even with headers on.
// - identify prints startup id string without reset or setting change.
// - alternate active query behaves exactly like the primary active query.
// - active query answers Y when protocol active, N otherwise.
// - key level read replies ON for high input, OFF for low.
// - power parameter bit 2 clear: key low interrupts activity, no power down.
// - every such interruption sends a STOPPED message to the host.
// - input reads reply 0 for low and 1 for high conditioned level.
// - reversed format, j1939 selected, exactly three bytes: bytes sent reversed.
// - raw byte order format disables the reversal; bytes sent as given.
// - after reset reversed format selected, raw format deselected.
// - grouping on (default) splits priority, pgn, source; off prints four bytes.
// - auto formatting off forces four plain id bytes regardless of grouping.
// - multiplier one (default) leaves timeout unscaled; same as alternate one.
// - multiplier five scales timeout by five; same as alternate five; off at reset.
// - linefeeds on add linefeed after each carriage return; off sends cr alone.
// - linefeed default latched from strap level at reset release.
// - after command carriage return, wait to see if a linefeed follows.
`include "obi_regs.vh"

module obi_option_cmd #(
    parameter LF_WAIT_CYCLES = `OBI_LF_WAIT_US * `OBI_CLK_MHZ,
    parameter [63:0] ID_TEXT = "OBI v1.0"   // arbitrary neutral identity text
) (
    // clock and reset
    input  wire        clk_sys,
    input  wire        rst_n,
    // register port
    input  wire [7:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata,
    // decoded commands and received characters
    input  wire        cmd_valid,
    input  wire [4:0]  cmd_code,
    input  wire [3:0]  cmd_arg,
    input  wire        rx_valid,
    input  wire [7:0]  rx_char,
    // reply characters
    output reg         tx_valid,
    output reg  [7:0]  tx_data,
    input  wire        tx_ready,
    // device state and pins
    input  wire        proto_active,
    input  wire        fc_data_defined,
    input  wire        fc_id_defined,
    input  wire        key_switch_monitor_input,
    input  wire        in1_level,
    input  wire        in2_level,
    input  wire        lf_strap,
    input  wire        obd_busy,
    output reg         obd_interrupt,
    output wire        power_down_req,
    // display formatting
    output wire        header_show,
    output wire        crc_show,
    output wire        id_grouped,
    output wire [1:0]  flow_mode,
    output wire        lf_enable,
    // j1939 outgoing data
    input  wire        j_valid_in,
    input  wire        j1939_sel,
    input  wire [3:0]  j_count,
    input  wire [63:0] j_data_in,
    output reg         j_valid_out,
    output reg  [63:0] j_data_out,
    // response timeout
    output reg  [10:0] timeout_scaled
);

    // ========
    // reply messages
    localparam [3:0] M_OK   = 4'h0;
    localparam [3:0] M_ERR  = 4'h1;
    localparam [3:0] M_Y    = 4'h2;
    localparam [3:0] M_N    = 4'h3;
    localparam [3:0] M_ON   = 4'h4;
    localparam [3:0] M_OFF  = 4'h5;
    localparam [3:0] M_ZERO = 4'h6;
    localparam [3:0] M_ONE  = 4'h7;
    localparam [3:0] M_ID   = 4'h8;
    localparam [3:0] M_STOP = 4'h9;

    localparam [2:0] T_IDLE = 3'h0;
    localparam [2:0] T_MSG  = 3'h1;
    localparam [2:0] T_LF   = 3'h2;
    localparam [2:0] T_PR   = 3'h3;

    localparam C_IDLE = 1'b0;
    localparam C_WAIT = 1'b1;

    localparam [31:0] WAIT_LAST = (LF_WAIT_CYCLES < 1) ? 32'h0 : LF_WAIT_CYCLES - 1;

    // character i of message m, zero marks the end
    function [7:0] msg_char;
        input [3:0] m;
        input [3:0] i;
        begin
            msg_char = 8'h00;
            case (m)
                M_OK:   msg_char = (i == 4'h0) ? 8'h4f : (i == 4'h1) ? 8'h4b : 8'h00;
                M_ERR:  msg_char = (i == 4'h0) ? 8'h3f : 8'h00;
                M_Y:    msg_char = (i == 4'h0) ? 8'h59 : 8'h00;
                M_N:    msg_char = (i == 4'h0) ? 8'h4e : 8'h00;
                M_ON:   msg_char = (i == 4'h0) ? 8'h4f : (i == 4'h1) ? 8'h4e : 8'h00;
                M_OFF:  msg_char = (i == 4'h0) ? 8'h4f : (i == 4'h1 || i == 4'h2) ? 8'h46 : 8'h00;
                M_ZERO: msg_char = (i == 4'h0) ? 8'h30 : 8'h00;
                M_ONE:  msg_char = (i == 4'h0) ? 8'h31 : 8'h00;
                M_ID:   msg_char = (i < 4'h8) ? ID_TEXT[63 - 8 * i -: 8] : 8'h00;
                M_STOP: begin
                    case (i)
                        4'h0:    msg_char = 8'h53;
                        4'h1:    msg_char = 8'h54;
                        4'h2:    msg_char = 8'h4f;
                        4'h3:    msg_char = 8'h50;
                        4'h4:    msg_char = 8'h50;
                        4'h5:    msg_char = 8'h45;
                        4'h6:    msg_char = 8'h44;
                        default: msg_char = 8'h00;
                    endcase
                end
                default: msg_char = 8'h00;
            endcase
        end
    endfunction

    // ========
    // state
    reg [7:0]  cfg_q;
    reg [7:0]  power_q;
    reg [7:0]  timeout_q;
    reg        strap_pend_q;
    reg        c_state_q;
    reg [4:0]  code_q;
    reg [3:0]  arg_q;
    reg [31:0] wait_q;
    reg [2:0]  t_state_q;
    reg [3:0]  msg_q;
    reg [3:0]  idx_q;
    reg        stop_pend_q;
    reg        stop_done_q;

    wire       tx_idle    = (t_state_q == T_IDLE);
    wire       slot_free  = !tx_valid || tx_ready;
    wire [7:0] cur_char   = msg_char(msg_q, idx_q);
    wire       lf_seen    = rx_valid && (rx_char == `OBI_CH_LF);
    // a linefeed right behind the cr, or the bounded wait, releases the command
    wire       exec_now   = (c_state_q == C_WAIT) && (lf_seen || wait_q >= WAIT_LAST);
    wire       key_intr   = obd_busy && !key_switch_monitor_input
                            && !power_q[`OBI_POWER_KEYOFF] && !stop_done_q;
    wire       fm_ok      = (cmd_arg_ok(arg_q)) &&
                            (arg_q == 4'h0 || (fc_data_defined && (arg_q == 4'h2 || fc_id_defined)));

    function cmd_arg_ok;
        input [3:0] a;
        begin
            cmd_arg_ok = (a <= 4'h2);
        end
    endfunction

    // ========
    // flag outputs
    assign header_show    = cfg_q[`OBI_CFG_HDR];
    assign crc_show       = 1'b0;
    assign id_grouped     = cfg_q[`OBI_CFG_GRP] && cfg_q[`OBI_CFG_AUTOFMT];
    assign flow_mode      = cfg_q[`OBI_CFG_FM_HI:`OBI_CFG_FM_LO];
    assign lf_enable      = cfg_q[`OBI_CFG_LF];
    assign power_down_req = !key_switch_monitor_input && power_q[`OBI_POWER_KEYOFF];

    // reply chosen for the released command
    reg [3:0] reply;
    always @* begin
        reply = M_OK;
        case (code_q)
            `OBI_C_FLOW_MODE:  reply = fm_ok ? M_OK : M_ERR;
            `OBI_C_IDENT:      reply = M_ID;
            `OBI_C_ACTIVE,
            `OBI_C_ALT_ACTIVE: reply = proto_active ? M_Y : M_N;
            `OBI_C_KEY_READ:   reply = key_switch_monitor_input ? M_ON : M_OFF;
            `OBI_C_IN1_READ:   reply = in1_level ? M_ONE : M_ZERO;
            `OBI_C_IN2_READ:   reply = in2_level ? M_ONE : M_ZERO;
            `OBI_C_HDR_OFF, `OBI_C_HDR_ON, `OBI_C_REV_PGN, `OBI_C_RAW_ORDER,
            `OBI_C_GRP_OFF, `OBI_C_GRP_ON, `OBI_C_AUTOFMT_OFF, `OBI_C_AUTOFMT_ON,
            `OBI_C_TM1, `OBI_C_TM5, `OBI_C_ALT_TM1, `OBI_C_ALT_TM5,
            `OBI_C_LF_OFF, `OBI_C_LF_ON: reply = M_OK;
            default:           reply = M_ERR;
        endcase
    end

    // ========
    // settings: command execution wins over a register write in the same cycle
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            cfg_q        <= `OBI_CFG_RST;
            power_q      <= `OBI_POWER_RST;
            timeout_q    <= `OBI_TIMEOUT_RST;
            strap_pend_q <= 1'b1;
        end else begin
            strap_pend_q <= 1'b0;
            if (strap_pend_q)
                cfg_q[`OBI_CFG_LF] <= lf_strap;
            if (reg_wr && !exec_now) begin
                if (reg_addr == `OBI_REG_CONFIG && !strap_pend_q)
                    cfg_q <= reg_wdata[7:0];
                if (reg_addr == `OBI_REG_POWER)
                    power_q <= reg_wdata[7:0];
                if (reg_addr == `OBI_REG_TIMEOUT)
                    timeout_q <= reg_wdata[7:0];
            end
            if (exec_now) begin
                case (code_q)
                    `OBI_C_FLOW_MODE:
                        if (fm_ok)
                            cfg_q[`OBI_CFG_FM_HI:`OBI_CFG_FM_LO] <= arg_q[1:0];
                    `OBI_C_HDR_OFF:     cfg_q[`OBI_CFG_HDR]     <= 1'b0;
                    `OBI_C_HDR_ON:      cfg_q[`OBI_CFG_HDR]     <= 1'b1;
                    `OBI_C_REV_PGN:     cfg_q[`OBI_CFG_REV]     <= 1'b1;
                    `OBI_C_RAW_ORDER:   cfg_q[`OBI_CFG_REV]     <= 1'b0;
                    `OBI_C_GRP_OFF:     cfg_q[`OBI_CFG_GRP]     <= 1'b0;
                    `OBI_C_GRP_ON:      cfg_q[`OBI_CFG_GRP]     <= 1'b1;
                    `OBI_C_AUTOFMT_OFF: cfg_q[`OBI_CFG_AUTOFMT] <= 1'b0;
                    `OBI_C_AUTOFMT_ON:  cfg_q[`OBI_CFG_AUTOFMT] <= 1'b1;
                    `OBI_C_TM1,
                    `OBI_C_ALT_TM1:     cfg_q[`OBI_CFG_TM5]     <= 1'b0;
                    `OBI_C_TM5,
                    `OBI_C_ALT_TM5:     cfg_q[`OBI_CFG_TM5]     <= 1'b1;
                    `OBI_C_LF_OFF:      cfg_q[`OBI_CFG_LF]      <= 1'b0;
                    `OBI_C_LF_ON:       cfg_q[`OBI_CFG_LF]      <= 1'b1;
                    default:            cfg_q <= cfg_q;                   // identify changes nothing
                endcase
            end
        end
    end

    // ========
    // command intake and linefeed wait
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            c_state_q <= C_IDLE;
            code_q    <= 5'h00;
            arg_q     <= 4'h0;
            wait_q    <= 32'h0;
        end else begin
            case (c_state_q)
                C_IDLE: begin
                    // commands during a reply are dropped
                    if (cmd_valid && tx_idle) begin
                        c_state_q <= C_WAIT;
                        code_q    <= cmd_code;
                        arg_q     <= cmd_arg;
                        wait_q    <= 32'h0;
                    end
                end
                C_WAIT: begin
                    wait_q <= wait_q + 32'h1;
                    if (exec_now)
                        c_state_q <= C_IDLE;
                end
                default: c_state_q <= C_IDLE;
            endcase
        end
    end

    // ========
    // key interrupt, one per busy episode
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            obd_interrupt <= 1'b0;
            stop_done_q   <= 1'b0;
            stop_pend_q   <= 1'b0;
        end else begin
            obd_interrupt <= key_intr;
            if (!obd_busy)
                stop_done_q <= 1'b0;
            else if (key_intr)
                stop_done_q <= 1'b1;
            // a new interruption beats the clear
            if (key_intr)
                stop_pend_q <= 1'b1;
            else if (tx_idle && !exec_now)
                stop_pend_q <= 1'b0;
        end
    end

    // ========
    // reply transmitter: message, cr, optional lf, prompt
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            t_state_q <= T_IDLE;
            msg_q     <= M_OK;
            idx_q     <= 4'h0;
            tx_valid  <= 1'b0;
            tx_data   <= 8'h00;
        end else begin
            if (tx_valid && tx_ready)
                tx_valid <= 1'b0;
            case (t_state_q)
                T_IDLE: begin
                    idx_q <= 4'h0;
                    if (exec_now) begin
                        msg_q     <= reply;
                        t_state_q <= T_MSG;
                    end else if (stop_pend_q) begin
                        msg_q     <= M_STOP;
                        t_state_q <= T_MSG;
                    end
                end
                T_MSG: begin
                    if (slot_free) begin
                        tx_valid <= 1'b1;
                        if (cur_char != 8'h00) begin
                            tx_data <= cur_char;
                            idx_q   <= idx_q + 4'h1;
                        end else begin
                            tx_data   <= `OBI_CH_CR;
                            t_state_q <= cfg_q[`OBI_CFG_LF] ? T_LF : T_PR;
                        end
                    end
                end
                T_LF: begin
                    if (slot_free) begin
                        tx_valid  <= 1'b1;
                        tx_data   <= `OBI_CH_LF;
                        t_state_q <= T_PR;
                    end
                end
                T_PR: begin
                    if (slot_free) begin
                        tx_valid  <= 1'b1;
                        tx_data   <= `OBI_CH_PROMPT;
                        t_state_q <= T_IDLE;
                    end
                end
                default: t_state_q <= T_IDLE;
            endcase
        end
    end

    // ========
    // j1939 byte order and timeout scaling
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            j_valid_out    <= 1'b0;
            j_data_out     <= 64'h0;
            timeout_scaled <= 11'h000;
        end else begin
            j_valid_out <= j_valid_in;
            if (j_valid_in) begin
                if (cfg_q[`OBI_CFG_REV] && j1939_sel && j_count == 4'h3)
                    j_data_out <= {j_data_in[47:40], j_data_in[55:48], j_data_in[63:56], j_data_in[39:0]};
                else
                    j_data_out <= j_data_in;
            end
            timeout_scaled <= cfg_q[`OBI_CFG_TM5] ? ({3'b000, timeout_q} * 11'd5)
                                                  : {3'b000, timeout_q};
        end
    end

    // ========
    // register read, data in the following cycle only
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0;
        end else if (reg_rd) begin
            case (reg_addr)
                `OBI_REG_CONFIG:  reg_rdata <= {24'h0, cfg_q};
                `OBI_REG_POWER:   reg_rdata <= {24'h0, power_q};
                `OBI_REG_TIMEOUT: reg_rdata <= {24'h0, timeout_q};
                `OBI_REG_STATUS:  reg_rdata <= {24'h0, stop_pend_q, key_switch_monitor_input, in2_level, in1_level,
                                                proto_active, !tx_idle, c_state_q, stop_done_q};
                default:          reg_rdata <= 32'h0;
            endcase
        end else begin
            reg_rdata <= 32'h0;
        end
    end

endmodule // obi_option_cmd

// [obi_host_model.sv]
// host side model: takes reply characters with random stalls and keeps them as text
module obi_host_model (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    // reply characters
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output logic            tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    string text;
    initial tx_ready = 1'b0;
    // stalls make the interpreter hold characters
    always @(posedge clk_sys) begin
        if (rst_n && tx_valid && tx_ready)
            text = {text, string'(tx_data)};
        tx_ready <= rst_n && ($urandom % 4 != 0);
    end
endmodule // obi_host_model

// [obi_option_cmd_checker.sv]
// port checks for the option command interpreter
module obi_option_cmd_checker (
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        rst_n,
    // watched ports
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        tx_valid,
    input wire logic [7:0]  tx_data,
    input wire logic        tx_ready,
    input wire logic        obd_busy,
    input wire logic        key_switch_monitor_input,
    input wire logic        obd_interrupt,
    input wire logic        crc_show,
    input wire logic        lf_strap,
    input wire logic        lf_enable,
    input wire logic        j_valid_in,
    input wire logic        j1939_sel,
    input wire logic [3:0]  j_count,
    input wire logic [63:0] j_data_in,
    input wire logic        j_valid_out,
    input wire logic [63:0] j_data_out
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // ========
    // j1939 data path, crc, read window, key interrupt, reply hold and linefeed strap
    sequence s_plain_in; j_valid_in && (!j1939_sel || j_count != 4'h3); endsequence
    sequence s_three_in; j_valid_in && j1939_sel && j_count == 4'h3; endsequence
    sequence s_same_out; j_valid_out && j_data_out == $past(j_data_in); endsequence
    sequence s_swap_out;
        j_valid_out && j_data_out == {$past(j_data_in[47:40]), $past(j_data_in[55:48]),
                                      $past(j_data_in[63:56]), $past(j_data_in[39:0])};
    endsequence
    property p_plain_pass; s_plain_in |=> s_same_out; endproperty
    property p_three_form; s_three_in |=> s_same_out or s_swap_out; endproperty
    property p_crc_off; crc_show == 1'b0; endproperty
    property p_rd_window; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
    property p_stop_cause; obd_interrupt |-> $past(obd_busy) && !$past(key_switch_monitor_input); endproperty
    property p_stop_pulse; obd_interrupt |=> !obd_interrupt [*3]; endproperty
    property p_tx_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data); endproperty
    property p_lf_strap; $rose(rst_n) |=> lf_enable == $past(lf_strap); endproperty
    a_plain_pass: assert property (p_plain_pass) else $error("j1939 data altered");
    a_three_form: assert property (p_three_form) else $error("three byte order wrong");
    a_crc_off: assert property (p_crc_off) else $error("crc shown");
    a_rd_window: assert property (p_rd_window) else $error("read data outside window");
    a_stop_cause: assert property (p_stop_cause) else $error("interrupt without cause");
    a_stop_pulse: assert property (p_stop_pulse) else $error("interrupt repeated");
    a_tx_hold: assert property (p_tx_hold) else $error("reply char dropped");
    a_lf_strap: assert property (p_lf_strap) else $error("linefeed default wrong");
endmodule // obi_option_cmd_checker
bind obi_option_cmd obi_option_cmd_checker obi_option_cmd_checker_inst (.*);

// [test_obd_interpreter_option_commands.sv]
// self-checking bench for the option command interpreter
`include "obi_regs.vh"
module test_obd_interpreter_option_commands;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LFW = 20;
    logic clk_sys, rst_n, reg_wr, reg_rd, cmd_valid, rx_valid, tx_valid, tx_ready, proto_active, obd_busy;
    logic fc_data_defined, fc_id_defined, key_switch_monitor_input, in1_level, in2_level, lf_strap;
    logic obd_interrupt, power_down_req, header_show, crc_show, id_grouped, lf_enable;
    logic j_valid_in, j1939_sel, j_valid_out, lfx, rf, ok;
    logic [7:0]  reg_addr, rx_char, tx_data, t;
    logic [31:0] reg_wdata, reg_rdata, v, w;
    logic [4:0]  cmd_code;
    logic [3:0]  cmd_arg, j_count, c;
    logic [1:0]  flow_mode, fm;
    logic [63:0] j_data_in, j_data_out, d;
    logic [10:0] timeout_scaled;
    int fails, checks, n;
    obi_option_cmd #(.LF_WAIT_CYCLES(LFW)) obi_option_cmd_inst (.*);
    obi_host_model obi_host_model_inst (.*);
    // ========
    // shared tasks
    task automatic check_val(string nm, logic [63:0] e, logic [63:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic check_str(string nm, string e, string g);
        checks++;
        if (g != e) begin
            fails++;
            $display("CHECK FAILED %s expected %s seen %s", nm, e, g);
        end
    endtask
    task automatic complete_run();
        if (fails == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic reg_write(logic [7:0] a, logic [31:0] x);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= x;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(logic [7:0] a, output logic [31:0] x);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        x = reg_rdata;
    endtask
    function automatic string exp(string b);
        string s;
        s = {b, "\r"};
        if (lfx)
            s = {s, "\n"};
        return {s, ">"};
    endfunction
    task automatic wait_prompt();
        for (int i = 0; i < 3000; i++) begin
            if (obi_host_model_inst.text.len() > 0 &&
                obi_host_model_inst.text[obi_host_model_inst.text.len() - 1] == `OBI_CH_PROMPT)
                break;
            @(posedge clk_sys);
        end
        repeat (2) @(posedge clk_sys);
    endtask
    // n: cycles from linefeed slot to first reply char
    task automatic send(logic [4:0] cd, logic [3:0] a, logic lf);
        obi_host_model_inst.text = "";
        @(posedge clk_sys);
        cmd_valid <= 1'b1;
        cmd_code <= cd;
        cmd_arg <= a;
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
        rx_valid <= lf;
        @(posedge clk_sys);
        rx_valid <= 1'b0;
        n = 0;
        while (tx_valid !== 1'b1 && n < 1000) begin
            @(negedge clk_sys);
            n++;
        end
        wait_prompt();
    endtask
    task automatic cmd(logic [4:0] cd, logic [3:0] a, string b);
        send(cd, a, 1'b1);
        check_val("lf_wait", 1, n <= 3);
        check_str("reply", exp(b), obi_host_model_inst.text);
    endtask
    // ========
    // stimulus
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    initial begin
        #200000;
        fails++;
        complete_run();
    end
    initial begin
        {reg_wr, reg_rd, cmd_valid, rx_valid, proto_active, obd_busy, fc_data_defined, fc_id_defined} = '0;
        {in1_level, in2_level, j_valid_in, j1939_sel, rst_n, reg_addr, reg_wdata, cmd_code, cmd_arg} = '0;
        {j_count, j_data_in} = '0;
        {lf_strap, key_switch_monitor_input, lfx, rf} = 4'hf;
        rx_char = `OBI_CH_LF;
        v = $urandom(32'h8233);
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        reg_read(`OBI_REG_CONFIG, w);
        check_val("config", `OBI_CFG_RST | 1, w);
        reg_read(`OBI_REG_POWER, v);
        check_val("power", `OBI_POWER_RST, v);
        reg_read(`OBI_REG_TIMEOUT, v);
        check_val("timeout", `OBI_TIMEOUT_RST, v);
        reg_read(8'h10, v);
        check_val("unmapped", 0, v);
        for (int k = 0; k < 5; k++) begin
            @(posedge clk_sys);
            {proto_active, key_switch_monitor_input, in1_level, in2_level} <= 4'(k == 0 ? 0 : $urandom);
            @(posedge clk_sys);
            cmd(`OBI_C_ACTIVE, 0, proto_active ? "Y" : "N");
            cmd(`OBI_C_ALT_ACTIVE, 0, proto_active ? "Y" : "N");
            cmd(`OBI_C_KEY_READ, 0, key_switch_monitor_input ? "ON" : "OFF");
            cmd(`OBI_C_IN1_READ, 0, in1_level ? "1" : "0");
            cmd(`OBI_C_IN2_READ, 0, in2_level ? "1" : "0");
        end
        cmd(`OBI_C_IDENT, 0, "OBI v1.0");
        reg_read(`OBI_REG_CONFIG, v);
        check_val("config", w, v);
        fm = 0;
        for (int m = 0; m < 12; m++) begin
            @(posedge clk_sys);
            fc_data_defined <= m > 3;
            fc_id_defined <= m > 7;
            @(posedge clk_sys);
            ok = m % 4 == 0 || (m % 4 == 1 && m > 7) || (m % 4 == 2 && m > 3);
            cmd(`OBI_C_FLOW_MODE, 4'(m % 4), ok ? "OK" : "?");
            if (ok)
                fm = 2'(m % 4);
            check_val("flow_mode", fm, flow_mode);
        end
        cmd(`OBI_C_HDR_ON, 0, "OK");
        check_val("header", 1, header_show);
        cmd(`OBI_C_HDR_OFF, 0, "OK");
        check_val("header", 0, header_show);
        cmd(`OBI_C_GRP_OFF, 0, "OK");
        check_val("grouped", 0, id_grouped);
        cmd(`OBI_C_AUTOFMT_OFF, 0, "OK");
        cmd(`OBI_C_GRP_ON, 0, "OK");
        check_val("grouped", 0, id_grouped);
        cmd(`OBI_C_AUTOFMT_ON, 0, "OK");
        check_val("grouped", 1, id_grouped);
        t = $urandom;
        reg_write(`OBI_REG_TIMEOUT, {24'h0, t});
        for (int i = 0; i < 4; i++) begin
            cmd(i == 0 ? `OBI_C_TM5 : i == 1 ? `OBI_C_TM1 : i == 2 ? `OBI_C_ALT_TM5 : `OBI_C_ALT_TM1, 0, "OK");
            check_val("timeout_scaled", i % 2 ? 11'(t) : 11'(t) * 11'h5, timeout_scaled);
        end
        send(`OBI_C_LF_OFF, 0, 1'b1);
        lfx = 0;
        check_val("lf_enable", 0, lf_enable);
        cmd(`OBI_C_ACTIVE, 0, proto_active ? "Y" : "N");
        send(`OBI_C_ACTIVE, 0, 1'b0);
        check_val("lf_timeout", 1, n >= LFW - 4 && n <= LFW + 4);
        send(`OBI_C_LF_ON, 0, 1'b1);
        lfx = 1;
        cmd(`OBI_C_ACTIVE, 0, proto_active ? "Y" : "N");
        for (int k = 0; k < 10; k++) begin
            if (k == 4)
                cmd(`OBI_C_RAW_ORDER, 0, "OK");
            if (k == 7)
                cmd(`OBI_C_REV_PGN, 0, "OK");
            rf = k < 4 || k > 6;
            d = {$urandom, $urandom};
            c = k % 2 ? 4'h3 : 4'($urandom_range(1, 8));
            @(posedge clk_sys);
            {j_valid_in, j1939_sel, j_count, j_data_in} <= {1'b1, k % 5 != 2, c, d};
            @(posedge clk_sys);
            j_valid_in <= 1'b0;
            @(negedge clk_sys);
            ok = rf && k % 5 != 2 && c == 4'h3;
            check_val("j_data", ok ? {d[47:40], d[55:48], d[63:56], d[39:0]} : d, j_data_out);
        end
        @(posedge clk_sys);
        key_switch_monitor_input <= 1'b0;
        @(negedge clk_sys);
        check_val("power_down", 1, power_down_req);
        reg_write(`OBI_REG_POWER, 32'h0);
        obi_host_model_inst.text = "";
        @(posedge clk_sys);
        obd_busy <= 1'b1;
        wait_prompt();
        check_val("power_down", 0, power_down_req);
        check_str("stopped", exp("STOPPED"), obi_host_model_inst.text);
        @(posedge clk_sys);
        {obd_busy, key_switch_monitor_input} <= 2'b01;
        repeat (4) @(posedge clk_sys);
        complete_run();
    end
endmodule // test_obd_interpreter_option_commands
